// ==== design/pif_flag_bank.sv ====
// module: eight sticky request flags, set by hardware, written by software
`timescale 1ns/100ps
module pif_flag_bank
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    pif_flag_if.bank fb
);
    import pif_pkg::*;

    logic [7:0] flag_reg;
    logic [7:0] flag_next;

    // set wins over a software write in the same cycle
    always_comb
    begin
        flag_next = flag_reg;
        if (fb.wr_en != 8'h00)
        begin
            flag_next = fb.wr_data;
        end
        flag_next = (flag_next | fb.event_set) & fb.impl_mask;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_reg <= RST_BYTE;
        end
        else if (clk_en)
        begin
            flag_reg <= flag_next;
        end
    end

    assign fb.flags = flag_reg;

    stick_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && fb.event_set[0] && fb.impl_mask[0]) |=> fb.flags[0])
        else $error("event did not set flag");
    hold_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && fb.wr_en == 8'h00 && fb.flags[3]) |=> fb.flags[3])
        else $error("flag cleared without software write");
endmodule

// ==== design/pif_flag_if.sv ====
// interface: per-bank event, write and flag signals between top and flag bank
`timescale 1ns/100ps
interface pif_flag_if;
    logic [7:0] event_set;
    logic [7:0] wr_en;
    logic [7:0] wr_data;
    logic [7:0] impl_mask;
    logic [7:0] flags;
    modport ctrl (output event_set, output wr_en, output wr_data, output impl_mask,
        input flags);
    modport bank (input event_set, input wr_en, input wr_data, input impl_mask,
        output flags);
endinterface

// ==== design/pif_irq_top.sv ====
// module: peripheral interrupt flags and enables with APB register access
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps

// Summary of operation
// - second enable: bits 6,3,2,1 writable
// - bits 7,5,4,0 unimplemented, read zero
// - enable gates its own flag only
// - group enable needed for any peripheral
// - flags set regardless of enables
// - first request: eight pending flags, fixed order
// - flag reads one while pending
// - second request: adc2, coll1, coll2, tmr4
// - collision flag stays until software clears
// - tmr4 flag sets on postscaled match
// - all bits reset to zero
// - global enable gates core_irq and, through core_next, the request status event behind bus_irq; not periph_irq_request
module pif_irq_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pif_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_one_gate_event,
    input wire logic adc_first_event,
    input wire logic uart_receive_event,
    input wire logic uart_transmit_event,
    input wire logic serial_port_one_event,
    input wire logic serial_port_two_event,
    input wire logic timer_two_match_event,
    input wire logic timer_one_overflow_event,
    input wire logic adc_second_event,
    input wire logic port_one_collision_event,
    input wire logic port_two_collision_event,
    input wire logic timer_four_postscaled_match,
    output logic periph_irq_request,
    output logic core_irq,
    output logic bus_irq
);
    import pif_pkg::*;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic access;
    logic wr_acc;
    logic lane0;
    logic hit_en2;
    logic hit_rq1;
    logic hit_rq2;
    logic hit_en1;
    logic hit_ctl;
    logic hit_sts;
    logic hit_msk;
    logic mapped;

    assign access = psel && penable && clk_en;
    assign wr_acc = access && pwrite;
    assign lane0 = pstrb[0];
    assign hit_en2 = (paddr == OFF_ENABLE_2);
    assign hit_rq1 = (paddr == OFF_REQUEST_1);
    assign hit_rq2 = (paddr == OFF_REQUEST_2);
    assign hit_en1 = (paddr == OFF_ENABLE_1);
    assign hit_ctl = (paddr == OFF_CONTROL);
    assign hit_sts = (paddr == OFF_BUS_STATUS);
    assign hit_msk = (paddr == OFF_BUS_MASK);
    assign mapped = hit_en2 || hit_rq1 || hit_rq2 || hit_en1 || hit_ctl || hit_sts || hit_msk;

    // zero-wait slave; clock enable low stretches the access
    assign pready = clk_en;
    assign pslverr = psel && penable && !mapped;

    // ------------------------------------------------------------
    // enable and control registers
    // ------------------------------------------------------------
    logic [7:0] enable_1_reg;
    logic [7:0] enable_2_reg;
    logic global_irq_enable_reg;
    logic peripheral_group_enable_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_1_reg <= RST_BYTE;
        end
        else if (wr_acc && lane0 && hit_en1)
        begin
            enable_1_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_2_reg <= RST_BYTE;
        end
        else if (wr_acc && lane0 && hit_en2)
        begin
            enable_2_reg <= pwdata[7:0] & MASK_REG2;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            global_irq_enable_reg <= 1'b0;
            peripheral_group_enable_reg <= 1'b0;
        end
        else if (wr_acc && lane0 && hit_ctl)
        begin
            global_irq_enable_reg <= pwdata[BIT_GIE];
            peripheral_group_enable_reg <= pwdata[BIT_PERIPHERAL_GROUP_ENABLE];
        end
    end

    // ------------------------------------------------------------
    // request flag banks
    // ------------------------------------------------------------
    pif_flag_if rq1_if ();
    pif_flag_if rq2_if ();

    // bit order 7..0: gate, adc1, rx, tx, ssp1, ssp2, tmr2, tmr1 overflow
    assign rq1_if.event_set = {timer_one_gate_event, adc_first_event, uart_receive_event,
        uart_transmit_event, serial_port_one_event, serial_port_two_event,
        timer_two_match_event, timer_one_overflow_event};
    assign rq1_if.wr_en = {8{wr_acc && lane0 && hit_rq1}};
    assign rq1_if.wr_data = pwdata[7:0];
    assign rq1_if.impl_mask = 8'hFF;

    // only the postscaled match reaches the tmr4 flag
    always_comb
    begin
        rq2_if.event_set = 8'h00;
        rq2_if.event_set[BIT_ADC2] = adc_second_event;
        rq2_if.event_set[BIT_COLL1] = port_one_collision_event;
        rq2_if.event_set[BIT_COLL2] = port_two_collision_event;
        rq2_if.event_set[BIT_TMR4] = timer_four_postscaled_match;
    end
    assign rq2_if.wr_en = {8{wr_acc && lane0 && hit_rq2}};
    assign rq2_if.wr_data = pwdata[7:0];
    assign rq2_if.impl_mask = MASK_REG2;

    pif_flag_bank u_rq1
    (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .fb(rq1_if.bank)
    );

    pif_flag_bank u_rq2
    (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .fb(rq2_if.bank)
    );

    // ------------------------------------------------------------
    // interrupt combination
    // ------------------------------------------------------------
    logic any_enabled;
    logic req_next;
    logic core_next;
    logic periph_req_reg;
    logic core_irq_reg;

    // each enable gates only the flag at its own position
    assign any_enabled = |(rq1_if.flags & enable_1_reg) |
        |(rq2_if.flags & enable_2_reg);
    assign req_next = any_enabled && peripheral_group_enable_reg;
    assign core_next = req_next && global_irq_enable_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            periph_req_reg <= 1'b0;
            core_irq_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            periph_req_reg <= req_next;
            core_irq_reg <= core_next;
        end
    end

    assign periph_irq_request = periph_req_reg;
    assign core_irq = core_irq_reg;

    // ------------------------------------------------------------
    // bus-side sticky status and mask
    // ------------------------------------------------------------
    logic [1:0] bus_sts_reg;
    logic [1:0] bus_msk_reg;
    logic [1:0] bus_evt;
    logic prev_core_reg;

    // blocked: a new flag event while core_next is low, i.e. no core request from the current flags
    assign bus_evt[BIT_EVT_BLOCKED] = (|rq1_if.event_set || |rq2_if.event_set) && !core_next;
    assign bus_evt[BIT_EVT_REQUEST] = core_next && !prev_core_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_core_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            prev_core_reg <= core_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_sts_reg <= RST_BUS_IRQ;
        end
        else if (clk_en)
        begin
            if (wr_acc && lane0 && hit_sts)
            begin
                bus_sts_reg <= (bus_sts_reg & ~pwdata[1:0]) | bus_evt;
            end
            else
            begin
                bus_sts_reg <= bus_sts_reg | bus_evt;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_msk_reg <= RST_BUS_IRQ;
        end
        else if (wr_acc && lane0 && hit_msk)
        begin
            bus_msk_reg <= pwdata[1:0];
        end
    end

    assign bus_irq = |(bus_sts_reg & bus_msk_reg);

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [31:0] rd_next;
    logic [31:0] prdata_reg;

    always_comb
    begin
        rd_next = RST_WORD;
        case (1'b1)
            hit_en2: rd_next[7:0] = enable_2_reg & MASK_REG2;
            hit_rq1: rd_next[7:0] = rq1_if.flags;
            hit_rq2: rd_next[7:0] = rq2_if.flags & MASK_REG2;
            hit_en1: rd_next[7:0] = enable_1_reg;
            hit_ctl:
            begin
                rd_next[BIT_GIE] = global_irq_enable_reg;
                rd_next[BIT_PERIPHERAL_GROUP_ENABLE] = peripheral_group_enable_reg;
            end
            hit_sts: rd_next[1:0] = bus_sts_reg;
            hit_msk: rd_next[1:0] = bus_msk_reg;
            default: rd_next = RST_WORD;
        endcase
    end

    // read data registered in the setup phase, valid through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= RST_WORD;
        end
        else if (clk_en && psel && !penable && !pwrite)
        begin
            prdata_reg <= rd_next;
        end
    end

    assign prdata = prdata_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    en2_unimpl_a: assert property (@(posedge pclk) disable iff (!presetn)
        (enable_2_reg & ~MASK_REG2) == 8'h00)
        else $error("unimplemented enable bit set");
    rq2_unimpl_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rq2_if.flags & ~MASK_REG2) == 8'h00)
        else $error("unimplemented request bit set");
    group_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !peripheral_group_enable_reg) |=> !periph_irq_request)
        else $error("request without group enable");
    global_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !global_irq_enable_reg) |=> !core_irq)
        else $error("core irq without global enable");
    core_req_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && any_enabled && peripheral_group_enable_reg && global_irq_enable_reg)
        |=> core_irq)
        else $error("core irq missing");
    enable_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && (rq1_if.flags & enable_1_reg) == 8'h00
        && (rq2_if.flags & enable_2_reg) == 8'h00) |=> !periph_irq_request)
        else $error("request with no enabled flag");
    tmr4_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && timer_four_postscaled_match) |=> rq2_if.flags[BIT_TMR4])
        else $error("tmr4 flag not set");
    adc1_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && adc_first_event && !global_irq_enable_reg) |=> rq1_if.flags[6])
        else $error("adc1 flag not set");
    coll_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && rq2_if.flags[BIT_COLL1] && !(wr_acc && hit_rq2))
        |=> rq2_if.flags[BIT_COLL1])
        else $error("collision flag dropped");
    coll1_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && psel && !penable && !pwrite && hit_rq2)
        |=> prdata[BIT_COLL1] == $past(rq2_if.flags[BIT_COLL1]))
        else $error("collision flag read wrong");

    irq_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
        !core_irq ##1 core_irq);
    coll_clear_c: cover property (@(posedge pclk) disable iff (!presetn)
        rq2_if.flags[BIT_COLL2] ##1 !rq2_if.flags[BIT_COLL2]);
    blocked_c: cover property (@(posedge pclk) disable iff (!presetn)
        bus_sts_reg[BIT_EVT_BLOCKED] && bus_msk_reg[BIT_EVT_BLOCKED] && bus_irq);
endmodule

// ==== design/pif_pkg.sv ====
// package: register map, field positions and reset values of the peripheral interrupt block
package pif_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_ENABLE_2 = 12'h000;
    localparam logic [11:0] OFF_REQUEST_1 = 12'h004;
    localparam logic [11:0] OFF_REQUEST_2 = 12'h008;
    localparam logic [11:0] OFF_ENABLE_1 = 12'h00C;
    localparam logic [11:0] OFF_CONTROL = 12'h010;
    localparam logic [11:0] OFF_BUS_STATUS = 12'h014;
    localparam logic [11:0] OFF_BUS_MASK = 12'h018;
    // second enable / request field positions
    localparam int BIT_ADC2 = 6;
    localparam int BIT_COLL1 = 3;
    localparam int BIT_COLL2 = 2;
    localparam int BIT_TMR4 = 1;
    // control register field positions
    localparam int BIT_GIE = 7;
    localparam int BIT_PERIPHERAL_GROUP_ENABLE = 6;
    // implemented-bit mask of the second registers
    localparam logic [7:0] MASK_REG2 = 8'h4E;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // bus status bits: flag event while no core request is pending, core request raised
    localparam int BIT_EVT_BLOCKED = 0;
    localparam int BIT_EVT_REQUEST = 1;
    localparam logic [1:0] RST_BUS_IRQ = 2'h0;
    localparam logic [31:0] RST_WORD = 32'h00000000;
endpackage

// ==== sim/pif_event_src.sv ====
// partner model: peripheral event sources that fire one-cycle pulses
`timescale 1ns/100ps
module pif_event_src
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] fire,
    output logic [11:0] evt
);
    // ----------------
    // event pulses
    // ----------------
    // one pulse per request; a source never clears a flag itself
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evt <= 12'h000;
        else
            evt <= fire;
    end
endmodule

// ==== sim/testbench.sv ====
// testbench: registers, event flags and interrupt outputs of the peripheral interrupt block
`timescale 1ns/100ps
module testbench;
    import pif_pkg::*;
    typedef struct packed
    {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } pif_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic [11:0] fire = 12'h000;
    logic [11:0] evt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic periph_irq_request;
    logic core_irq;
    logic bus_irq;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    logic [11:0] offs [7] = '{OFF_ENABLE_2, OFF_REQUEST_1, OFF_REQUEST_2, OFF_ENABLE_1,
        OFF_CONTROL, OFF_BUS_STATUS, OFF_BUS_MASK};
    logic [7:0] r2b [4] = '{8'h40, 8'h08, 8'h04, 8'h02};
    pif_row_t rows [10] = '{'{OFF_ENABLE_2, 8'hFF, 8'h4E}, '{OFF_ENABLE_2, 8'h00, 8'h00},
        '{OFF_REQUEST_1, 8'hA5, 8'hA5}, '{OFF_REQUEST_1, 8'h00, 8'h00},
        '{OFF_REQUEST_2, 8'hFF, 8'h4E}, '{OFF_REQUEST_2, 8'h00, 8'h00},
        '{OFF_ENABLE_1, 8'h3C, 8'h3C}, '{OFF_ENABLE_1, 8'h00, 8'h00},
        '{OFF_BUS_MASK, 8'h03, 8'h03}, '{OFF_BUS_MASK, 8'h00, 8'h00}};

    always #5 pclk = ~pclk;

    pif_event_src u_pif_event_src (.pclk(pclk), .presetn(presetn), .fire(fire), .evt(evt));

    pif_irq_top u_pif_irq_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_one_gate_event(evt[7]), .adc_first_event(evt[6]),
        .uart_receive_event(evt[5]), .uart_transmit_event(evt[4]),
        .serial_port_one_event(evt[3]), .serial_port_two_event(evt[2]),
        .timer_two_match_event(evt[1]), .timer_one_overflow_event(evt[0]),
        .adc_second_event(evt[8]), .port_one_collision_event(evt[9]),
        .port_two_collision_event(evt[10]), .timer_four_postscaled_match(evt[11]),
        .periph_irq_request(periph_irq_request), .core_irq(core_irq), .bus_irq(bus_irq));

    // ----------------
    // checking and closing
    // ----------------
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // level outputs are sampled mid-cycle, then realigned to the rising edge
    task automatic check_bit(ref logic got_in, input logic exp);
        @(negedge pclk);
        check_count++;
        if (got_in !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got_in, exp);
        end
        @(posedge pclk);
    endtask

    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            report_and_stop();
        end
    end

    // ----------------
    // bus and event drivers
    // ----------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        check_val(r, {24'h000000, exp});
    endtask

    task automatic pulse(input logic [11:0] m);
        fire <= m;
        @(posedge pclk);
        fire <= 12'h000;
        repeat (4) @(posedge pclk);
    endtask

    task automatic clear_flags();
        wr(OFF_REQUEST_1, 8'h00);
        wr(OFF_REQUEST_2, 8'h00);
    endtask

    // ----------------
    // main sequence
    // ----------------
    initial
    begin
        logic [31:0] r;
        logic e;
        logic [15:0] b;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (offs[k]) rd_chk(offs[k], 8'h00);
        $display("test reset_values done");
        foreach (rows[k])
        begin
            wr(rows[k].addr, rows[k].wdata);
            rd_chk(rows[k].addr, rows[k].exp);
        end
        $display("test register_table done");
        pulse(12'hFFF);
        rd_chk(OFF_REQUEST_1, 8'hFF);
        rd_chk(OFF_REQUEST_2, MASK_REG2);
        check_bit(core_irq, 1'b0);
        clear_flags();
        rd_chk(OFF_REQUEST_1, 8'h00);
        $display("test flags_without_enables done");
        wr(OFF_CONTROL, 8'hC0);
        for (int i = 0; i < 12; i++)
        begin
            b = (i < 8) ? {8'h00, 8'h01 << i} : {r2b[i - 8], 8'h00};
            clear_flags();
            wr(OFF_ENABLE_1, b[7:0]);
            wr(OFF_ENABLE_2, b[15:8]);
            pulse(12'h001 << ((i + 1) % 12));
            check_bit(core_irq, 1'b0);
            pulse(12'h001 << i);
            check_bit(periph_irq_request, 1'b1);
            check_bit(core_irq, 1'b1);
        end
        $display("test per_source_gating done");
        wr(OFF_CONTROL, 8'h80);
        check_bit(periph_irq_request, 1'b0);
        check_bit(core_irq, 1'b0);
        wr(OFF_CONTROL, 8'h40);
        check_bit(periph_irq_request, 1'b1);
        check_bit(core_irq, 1'b0);
        $display("test group_global done");
        pulse(12'h200);
        repeat (50) @(posedge pclk);
        rd_chk(OFF_REQUEST_2, 8'h0A);
        wr(OFF_REQUEST_2, 8'h00);
        rd_chk(OFF_REQUEST_2, 8'h00);
        $display("test collision_sticky done");
        apb(1'b1, 12'h01C, 8'hFF, r, e);
        check_bit(e, 1'b1);
        apb(1'b0, 12'h01C, 8'h00, r, e);
        check_val(r, 32'h00000000);
        check_bit(e, 1'b1);
        pstrb <= 4'h0;
        wr(OFF_ENABLE_1, 8'hFF);
        pstrb <= 4'hF;
        rd_chk(OFF_ENABLE_1, 8'h00);
        $display("test refused_access done");
        wr(OFF_REQUEST_2, 8'h02);
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_BUS_STATUS, 8'h03);
        wr(OFF_BUS_MASK, 8'h00);
        pulse(12'h001);
        rd_chk(OFF_BUS_STATUS, 8'h01);
        check_bit(bus_irq, 1'b0);
        wr(OFF_BUS_MASK, 8'h01);
        check_bit(bus_irq, 1'b1);
        wr(OFF_BUS_STATUS, 8'h01);
        rd_chk(OFF_BUS_STATUS, 8'h00);
        check_bit(bus_irq, 1'b0);
        wr(OFF_BUS_MASK, 8'h02);
        wr(OFF_CONTROL, 8'hC0);
        check_bit(core_irq, 1'b1);
        apb(1'b0, OFF_BUS_STATUS, 8'h00, r, e);
        check_val(r & 32'h00000002, 32'h00000002);
        check_bit(bus_irq, 1'b1);
        $display("test bus_interrupt done");
        clk_en <= 1'b0;
        pulse(12'h100);
        clk_en <= 1'b1;
        rd_chk(OFF_REQUEST_2, 8'h02);
        $display("test clock_enable_freeze done");
        presetn <= 1'b0;
        @(posedge pclk);
        check_bit(core_irq, 1'b0);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (offs[k]) rd_chk(offs[k], 8'h00);
        $display("test second_reset done");
        report_and_stop();
    end
endmodule
